// File: shared/bftr_pkg.sv
// Package of register map, reset values and timing for the fault timing block
package bftr_pkg;
  // ----------------------------------------
  // Register map, byte addresses
  // ----------------------------------------
  localparam logic [7:0] SHORT_DLY_OFF = 8'h00;
  localparam logic [7:0] LIMIT_OFF     = 8'h04;
  localparam logic [7:0] REC_TIME_OFF  = 8'h08;
  localparam logic [7:0] OTC_THR_OFF   = 8'h0C;
  localparam logic [7:0] OTC_DLY_OFF   = 8'h10;
  localparam logic [7:0] OTC_REC_OFF   = 8'h14;
  localparam logic [7:0] STATUS_OFF    = 8'h18;
  localparam logic [7:0] MASK_OFF      = 8'h1C;
  localparam logic [7:0] STATE_OFF     = 8'h20;
  localparam logic [7:0] RETRY_OFF     = 8'h24;
  localparam logic [7:0] CTRL_OFF      = 8'h28;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [3:0] SHORT_DLY_RST = 4'h1;
  localparam logic [2:0] LIMIT_RST     = 3'h0;
  localparam logic [7:0] REC_TIME_RST  = 8'h05;
  localparam logic [7:0] OTC_THR_RST   = 8'h37;
  localparam logic [7:0] OTC_DLY_RST   = 8'h0F;
  localparam logic [7:0] OTC_REC_RST   = 8'h3F;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int ST_SCD     = 0;
  localparam int ST_OC      = 1;
  localparam int ST_LATCH   = 2;
  localparam int ST_RECOV   = 3;
  localparam int ST_OTC_SET = 4;
  localparam int ST_OTC_CLR = 5;
  localparam int ST_W       = 6;
  localparam int CTRL_CLR   = 0;

  // ----------------------------------------
  // Code tables and scaling
  // ----------------------------------------
  localparam logic [3:0] SCD_CODE_MAX = 4'hA;
  // Short fault delay in microseconds: 0, 15, 31 ... 7797
  localparam logic [12:0] SCD_DLY_US [0:10] = '{
    13'h0000, 13'h000F, 13'h001F, 13'h003D, 13'h007A, 13'h00F4,
    13'h01E8, 13'h03D1, 13'h07A1, 13'h0F42, 13'h1E75};
  // Retries before latch: off, 2, 4, 8, 16, 32, 48, 96
  localparam logic [6:0] RETRY_LIM [0:7] = '{
    7'h00, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h30, 7'h60};
  localparam logic [15:0] TS_STEP = 16'h0036;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS      = 25;
  localparam int US_NS       = 1000;
  localparam int US_CYC      = US_NS / CLK_NS;
  localparam int SEC_US_DFLT = 1000000;
  localparam logic [2:0] QUIET_SEC = 3'h5;

  typedef enum logic [1:0] {
    CF_IDLE    = 2'b00,
    CF_TRIP    = 2'b01,
    CF_LATCHED = 2'b10
  } bftr_cf_state_t;
endpackage

// File: logic/bftr_tick_div.sv
// Restartable divider that turns step pulses into one tick every DIV steps
`timescale 1ns/100ps
module bftr_tick_div #(
  parameter int unsigned DIV = 40
) (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic ce,
  input  wire logic restart,
  input  wire logic step,
  output logic      tick
);
  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;

  logic [W-1:0] cnt_reg;

  // Restart realigns the phase so that timed waits start exactly
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else if (ce) begin
      tick <= 1'b0;
      if (restart) begin
        cnt_reg <= '0;
      end else if (step) begin
        if (cnt_reg == W'(DIV - 1)) begin
          cnt_reg <= '0;
          tick    <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + W'(1);
        end
      end
    end
  end
endmodule

// File: logic/bftr_core.sv
// Current fault delay, retry latch, auto recovery and charge overtemperature logic
`timescale 1ns/100ps
module bftr_core
  import bftr_pkg::*;
#(
  parameter int unsigned SEC_US = SEC_US_DFLT
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic        short_circuit_discharge_fault,
  input  wire logic        discharge_overcurrent_one,
  input  wire logic        discharge_overcurrent_two,
  input  wire logic        charge_overcurrent_fault,
  input  wire logic [15:0] thermistor_input,
  input  wire logic        thermistor_valid,
  input  wire logic        latch_clear,
  output logic [7:0]       rd_data,
  output logic             irq,
  output logic             fet_off,
  output logic             fets_latched,
  output logic             otc_alert
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [3:0]      short_fault_delay_code;
  logic [2:0]      retry_limit_code;
  logic [7:0]      rec_time_reg, otc_thr_reg, otc_dly_reg, otc_rec_reg;
  logic [ST_W-1:0] status_reg, mask_reg, events;
  bftr_cf_state_t  cf_state;
  logic [12:0]     scd_us_reg;
  logic [7:0]      sec_cnt_reg;
  logic [6:0]      retry_reg;
  logic [2:0]      quiet_cnt_reg;
  logic [7:0]      below_cnt_reg;
  logic            quiet_run_reg, otc_reg;
  logic            us_tick, sec_tick, sec_restart;
  logic            scd_hit, oc_any, cur_trip;
  logic            clr_sw, clr_any, rec_event;
  logic [6:0]      retry_inc, retry_lim;
  logic            limit_hit, quiet_expire;
  logic [15:0]     otc_thr_val, otc_rec_val;
  logic            ts_below, ts_above, otc_set_ev, otc_clr_ev;

  // ----------------------------------------
  // Timebase
  // ----------------------------------------
  // Microsecond tick, then second tick counted in microseconds
  bftr_tick_div #(.DIV(US_CYC)) u_us_div (
    .mclk    (mclk),
    .nrst    (nrst),
    .ce      (ce),
    .restart (sec_restart),
    .step    (1'b1),
    .tick    (us_tick)
  );

  bftr_tick_div #(.DIV(SEC_US)) u_sec_div (
    .mclk    (mclk),
    .nrst    (nrst),
    .ce      (ce),
    .restart (sec_restart),
    .step    (us_tick),
    .tick    (sec_tick)
  );

  // Both waits are timed from their start, so realign on entry
  assign sec_restart = ((cf_state == CF_IDLE) && cur_trip) || rec_event;

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Reset defaults of settings
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      short_fault_delay_code <= SHORT_DLY_RST;
      retry_limit_code       <= LIMIT_RST;
      rec_time_reg           <= REC_TIME_RST;
      otc_thr_reg            <= OTC_THR_RST;
      otc_dly_reg            <= OTC_DLY_RST;
      otc_rec_reg            <= OTC_REC_RST;
      mask_reg               <= '0;
    end else if (ce && wr_en) begin
      unique case (addr)
        // Invalid codes above ten are ignored
        SHORT_DLY_OFF: if (wr_data[3:0] <= SCD_CODE_MAX) begin
          short_fault_delay_code <= wr_data[3:0];
        end
        LIMIT_OFF:     retry_limit_code <= wr_data[2:0];
        REC_TIME_OFF:  rec_time_reg <= wr_data;
        OTC_THR_OFF:   otc_thr_reg <= wr_data;
        OTC_DLY_OFF:   otc_dly_reg <= wr_data;
        OTC_REC_OFF:   otc_rec_reg <= wr_data;
        MASK_OFF:      mask_reg <= wr_data[ST_W-1:0];
        default:       ;
      endcase
    end
  end

  assign clr_sw  = wr_en && (addr == CTRL_OFF) && wr_data[CTRL_CLR];
  assign clr_any = clr_sw || latch_clear;

  // ----------------------------------------
  // Short fault qualification
  // ----------------------------------------
  // Delay compare against the code table
  assign scd_hit = short_circuit_discharge_fault &&
                   ((short_fault_delay_code == 4'h0) ||
                    (scd_us_reg >= SCD_DLY_US[short_fault_delay_code]));
  assign oc_any  = discharge_overcurrent_one || discharge_overcurrent_two ||
                   charge_overcurrent_fault;
  assign cur_trip = scd_hit || oc_any;

  // Microseconds the comparator has held, saturating
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      scd_us_reg <= '0;
    end else if (ce) begin
      if (!short_circuit_discharge_fault || (cf_state != CF_IDLE)) begin
        scd_us_reg <= '0;
      end else if (us_tick && (scd_us_reg != 13'h1FFF)) begin
        scd_us_reg <= scd_us_reg + 13'h0001;
      end
    end
  end

  // ----------------------------------------
  // Recovery and retry latch
  // ----------------------------------------
  // Zero recovery time never recovers
  assign rec_event = (cf_state == CF_TRIP) && (rec_time_reg != 8'h00) &&
                     (sec_cnt_reg >= rec_time_reg) && !clr_any;
  assign retry_inc = (retry_reg == 7'h7F) ? retry_reg : retry_reg + 7'h01;
  assign retry_lim = RETRY_LIM[retry_limit_code];
  assign limit_hit = (retry_lim != 7'h00) && (retry_inc >= retry_lim);
  assign quiet_expire = quiet_run_reg && sec_tick && !cur_trip &&
                        (quiet_cnt_reg == QUIET_SEC - 3'h1);

  // Shared fault state for all current faults
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cf_state <= CF_IDLE;
    end else if (ce) begin
      unique case (cf_state)
        CF_IDLE: if (cur_trip) begin
          cf_state <= CF_TRIP;
        end
        CF_TRIP: if (clr_any) begin
          cf_state <= CF_IDLE;
        end else if (rec_event) begin
          cf_state <= limit_hit ? CF_LATCHED : CF_IDLE;
        end
        CF_LATCHED: if (clr_any) begin
          cf_state <= CF_IDLE;
        end
        default: cf_state <= CF_IDLE;
      endcase
    end
  end

  // Whole seconds spent in the tripped state
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sec_cnt_reg <= '0;
    end else if (ce) begin
      if (cf_state != CF_TRIP) begin
        sec_cnt_reg <= '0;
      end else if (sec_tick && (sec_cnt_reg != 8'hFF)) begin
        sec_cnt_reg <= sec_cnt_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      retry_reg <= '0;
    end else if (ce) begin
      if (clr_any && (cf_state != CF_IDLE)) begin
        retry_reg <= '0;
      end else if (quiet_expire) begin
        retry_reg <= '0;
      end else if (rec_event) begin
        retry_reg <= retry_inc;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      quiet_run_reg <= 1'b0;
      quiet_cnt_reg <= '0;
    end else if (ce) begin
      if (rec_event && !limit_hit) begin
        quiet_run_reg <= 1'b1;
        quiet_cnt_reg <= '0;
      end else if (cur_trip || quiet_expire) begin
        quiet_run_reg <= 1'b0;
      end else if (quiet_run_reg && sec_tick) begin
        quiet_cnt_reg <= quiet_cnt_reg + 3'h1;
      end
    end
  end

  // ----------------------------------------
  // Charge overtemperature
  // ----------------------------------------
  // Trip threshold in steps of 54 codes
  assign otc_thr_val = 16'(otc_thr_reg) * TS_STEP;
  // Release threshold in steps of 54 codes
  assign otc_rec_val = 16'(otc_rec_reg) * TS_STEP;
  assign ts_below    = thermistor_input < otc_thr_val;
  assign ts_above    = thermistor_input > otc_rec_val;
  assign otc_set_ev  = thermistor_valid && !otc_reg && ts_below &&
                       (below_cnt_reg >= otc_dly_reg);
  assign otc_clr_ev  = thermistor_valid && otc_reg && ts_above;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      otc_reg       <= 1'b0;
      below_cnt_reg <= '0;
    end else if (ce && thermistor_valid) begin
      if (otc_set_ev) begin
        otc_reg       <= 1'b1;
        below_cnt_reg <= '0;
      end else if (otc_clr_ev) begin
        otc_reg <= 1'b0;
      end else if (!otc_reg && ts_below) begin
        below_cnt_reg <= below_cnt_reg + 8'h01;
      end else begin
        below_cnt_reg <= '0;
      end
    end
  end

  // ----------------------------------------
  // Status, interrupt and outputs
  // ----------------------------------------
  always_comb begin
    events             = '0;
    events[ST_SCD]     = (cf_state == CF_IDLE) && scd_hit;
    events[ST_OC]      = (cf_state == CF_IDLE) && oc_any;
    events[ST_LATCH]   = rec_event && limit_hit;
    events[ST_RECOV]   = rec_event && !limit_hit;
    events[ST_OTC_SET] = otc_set_ev;
    events[ST_OTC_CLR] = otc_clr_ev;
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      status_reg <= '0;
    end else if (ce) begin
      if (wr_en && (addr == STATUS_OFF)) begin
        status_reg <= (status_reg & ~wr_data[ST_W-1:0]) | events;
      end else begin
        status_reg <= status_reg | events;
      end
    end
  end

  // Outputs lag their source state by one cycle
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      irq          <= 1'b0;
      fet_off      <= 1'b0;
      fets_latched <= 1'b0;
      otc_alert    <= 1'b0;
    end else if (ce) begin
      irq          <= |(status_reg & mask_reg);
      fet_off      <= cf_state != CF_IDLE;
      fets_latched <= cf_state == CF_LATCHED;
      otc_alert    <= otc_reg;
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rd_data <= '0;
    end else if (ce) begin
      rd_data <= 8'h00;
      if (rd_en) begin
        unique case (addr)
          SHORT_DLY_OFF: rd_data <= {4'h0, short_fault_delay_code};
          LIMIT_OFF:     rd_data <= {5'h00, retry_limit_code};
          REC_TIME_OFF:  rd_data <= rec_time_reg;
          OTC_THR_OFF:   rd_data <= otc_thr_reg;
          OTC_DLY_OFF:   rd_data <= otc_dly_reg;
          OTC_REC_OFF:   rd_data <= otc_rec_reg;
          STATUS_OFF:    rd_data <= {2'h0, status_reg};
          MASK_OFF:      rd_data <= {2'h0, mask_reg};
          STATE_OFF:     rd_data <= {5'h00, otc_reg, cf_state};
          RETRY_OFF:     rd_data <= {1'b0, retry_reg};
          default:       rd_data <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_scd_trip_now: assert property (
    ce && (cf_state == CF_IDLE) && scd_hit |=> cf_state == CF_TRIP)
    else $error("Qualified short fault did not trip");
  a_no_early_trip: assert property (
    ce && (cf_state == CF_IDLE) && !cur_trip |=> cf_state == CF_IDLE)
    else $error("Trip without a qualified fault");
  a_latch_at_limit: assert property (
    ce && rec_event && limit_hit |=> cf_state == CF_LATCHED ##1 fets_latched)
    else $error("Retry limit reached but not latched");
  a_limit_off: assert property (
    ce && rec_event && (retry_limit_code == 3'h0) |=> cf_state == CF_IDLE)
    else $error("Latched with latching disabled");
  a_quiet_clear: assert property (
    ce && quiet_expire |=> retry_reg == 7'h00)
    else $error("Retry count not cleared after quiet time");
  a_rec_disabled: assert property (
    ce && (cf_state == CF_TRIP) && (rec_time_reg == 8'h00) && !clr_any |=> cf_state == CF_TRIP)
    else $error("Recovery with recovery disabled");
  a_otc_trip: assert property (
    ce && thermistor_valid && !otc_reg && ts_below &&
    (below_cnt_reg >= otc_dly_reg) |=> otc_reg ##1 otc_alert)
    else $error("Overtemperature not raised");
  a_otc_wait: assert property (
    ce && thermistor_valid && !otc_reg && (below_cnt_reg < otc_dly_reg) |=> !otc_reg)
    else $error("Overtemperature raised early");
  a_cfg_reset: assert property (
    $rose(nrst) |-> (short_fault_delay_code == 4'h1) && (retry_limit_code == 3'h0))
    else $error("Wrong setting after reset");
  a_otc_release: assert property (
    ce && otc_clr_ev |=> !otc_reg)
    else $error("Overtemperature not released");
  a_latch_holds: assert property (
    (cf_state == CF_LATCHED) && !clr_any |=> cf_state == CF_LATCHED)
    else $error("Latch released without clear");

  c_latched: cover property (ce && rec_event && limit_hit);
  c_recovered: cover property (ce && rec_event && !limit_hit);
  c_quiet: cover property (ce && quiet_expire && (retry_reg != 7'h00));
  c_otc_cycle: cover property (ce && otc_set_ev);
endmodule

// File: dv/bftr_far_model.sv
// Model of the current comparators and thermistor measurement feeding the block
`timescale 1ns/100ps
module bftr_far_model (
  input  wire logic        mclk,
  output logic             short_flt,
  output logic [2:0]       oc_flt,
  output logic [15:0]      ts_val,
  output logic             ts_vld
);
  // ----------------------------------------
  // Idle levels
  // ----------------------------------------
  initial begin
    short_flt = 1'b0;
    oc_flt    = 3'h0;
    ts_val    = 16'hFFFF;
    ts_vld    = 1'b0;
  end

  // One measurement; value inverted after so stale data never matches
  task automatic sample(input logic [15:0] v);
    @(posedge mclk);
    ts_val <= v;
    ts_vld <= 1'b1;
    @(posedge mclk);
    ts_val <= ~v;
    ts_vld <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
  endtask

  // Comparator levels, bit 0 and 1 discharge, bit 2 charge
  task automatic faults(input logic s, input logic [2:0] oc);
    @(posedge mclk);
    short_flt <= s;
    oc_flt    <= oc;
  endtask
endmodule

// File: dv/tb_bftr_core.sv
// Self-checking bench for the fault timing and recovery block
`timescale 1ns/100ps
module tb_bftr_core;
  import bftr_pkg::*;
  localparam int SEC = 400;   // Cycles per second with SEC_US of 10
  localparam int LIMIT = 12000;
  logic        mclk, nrst, ce, wr_en, rd_en, latch_clear;
  logic [7:0]  addr, wr_data, rd_data, rv;
  logic        short_flt, ts_vld, irq, fet_off, fets_latched, otc_alert;
  logic [2:0]  oc_flt;
  logic [15:0] ts_val;
  int          error_cnt, num_checks, cyc;

  bftr_far_model p (.mclk(mclk), .short_flt(short_flt), .oc_flt(oc_flt),
    .ts_val(ts_val), .ts_vld(ts_vld));
  bftr_core #(.SEC_US(10)) dut (.mclk(mclk), .nrst(nrst), .ce(ce), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .short_circuit_discharge_fault(short_flt), .discharge_overcurrent_one(oc_flt[0]),
    .discharge_overcurrent_two(oc_flt[1]), .charge_overcurrent_fault(oc_flt[2]),
    .thermistor_input(ts_val), .thermistor_valid(ts_vld), .latch_clear(latch_clear),
    .rd_data(rd_data), .irq(irq), .fet_off(fet_off), .fets_latched(fets_latched),
    .otc_alert(otc_alert));

  // ----------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------
  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;

  // Hang guard, sized well above the sum of all scenarios
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1;
    rv = rd_data;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Bounded wait on the FET disable output, then judged
  task automatic wait_fet(input logic v, input int lim);
    int n;
    n = 0;
    // Step off the launching edge so the output has settled
    #1;
    while (fet_off !== v && n < lim) begin
      cycles(1);
      n++;
    end
    chk("fet_off", 8'(v), 8'(fet_off));
  endtask

  // Clear trip or latch, and with it the retry count, through the control register
  task automatic clear_all();
    p.faults(1'b0, 3'h0);
    wr(CTRL_OFF, 8'h01);
    wait_fet(1'b0, 5);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // reset values, refused code, limit codes
  task automatic t_regs();
    rd(SHORT_DLY_OFF);
    chk("short delay", 8'h01, rv);
    rd(LIMIT_OFF);
    chk("limit", 8'h00, rv);
    wr(SHORT_DLY_OFF, 8'h0A);
    wr(SHORT_DLY_OFF, 8'h0B);
    rd(SHORT_DLY_OFF);
    chk("short delay max", 8'h0A, rv);
    for (int i = 0; i < 8; i++) begin
      wr(LIMIT_OFF, 8'(i));
      rd(LIMIT_OFF);
      chk("limit code", 8'(i), rv);
    end
    wr(LIMIT_OFF, 8'h00);
    rd(8'h30);
    chk("unmapped", 8'h00, rv);
    $display("test regs done");
  endtask

  // short delay codes 0 and 1, irq masking and clearing
  task automatic t_short();
    wr(SHORT_DLY_OFF, 8'h00);
    wr(MASK_OFF, 8'h01);
    p.faults(1'b1, 3'h0);
    cycles(1);
    chk("fet_off c1", 8'h00, 8'(fet_off));
    cycles(1);
    chk("fet_off c2", 8'h01, 8'(fet_off));
    chk("irq", 8'h01, 8'(irq));
    rd(STATUS_OFF);
    chk("status", 8'h01, rv & 8'h01);
    wr(STATUS_OFF, 8'h01);
    cycles(1);
    chk("irq cleared", 8'h00, 8'(irq));
    clear_all();
    // Code 1 is 15 us; a 300 cycle glitch must not accumulate
    wr(SHORT_DLY_OFF, 8'h01);
    p.faults(1'b1, 3'h0);
    cycles(300);
    p.faults(1'b0, 3'h0);
    cycles(400);
    chk("glitch", 8'h00, 8'(fet_off));
    // Free running microsecond tick makes the delay 14 to 15 us
    p.faults(1'b1, 3'h0);
    cycles(14 * US_CYC);
    chk("early", 8'h00, 8'(fet_off));
    wait_fet(1'b1, US_CYC + 10);
    clear_all();
    $display("test short done");
  endtask

  // held charge fault latches after two retries
  task automatic t_latch();
    wr(REC_TIME_OFF, 8'h01);
    wr(LIMIT_OFF, 8'h01);
    p.faults(1'b0, 3'b100);
    wait_fet(1'b1, 5);
    cycles(SEC + SEC / 2);
    chk("latched early", 8'h00, 8'(fets_latched));
    rd(RETRY_OFF);
    chk("retry count", 8'h01, rv);
    cycles(SEC / 2 + 20);
    chk("latched", 8'h01, 8'(fets_latched));
    rd(STATUS_OFF);
    chk("status latch", 8'h0E, rv & 8'h0E);
    rd(STATE_OFF);
    chk("state latched", 8'h02, rv & 8'h03);
    cycles(2 * SEC);
    chk("stays off", 8'h01, 8'(fet_off));
    p.faults(1'b0, 3'h0);
    @(posedge mclk);
    latch_clear <= 1'b1;
    @(posedge mclk);
    latch_clear <= 1'b0;
    wait_fet(1'b0, 5);
    chk("unlatched", 8'h00, 8'(fets_latched));
    clear_all();
    $display("test latch done");
  endtask

  // shared count of two discharge faults, cleared after 5 s quiet
  task automatic t_quiet();
    wr(LIMIT_OFF, 8'h02);
    for (int i = 0; i < 2; i++) begin
      p.faults(1'b0, 3'(1 << i));
      p.faults(1'b0, 3'h0);
      wait_fet(1'b1, 5);
      wait_fet(1'b0, SEC + 10);
    end
    rd(RETRY_OFF);
    chk("shared count", 8'h02, rv);
    cycles(5 * SEC - 40);
    rd(RETRY_OFF);
    chk("count held", 8'h02, rv);
    cycles(60);
    rd(RETRY_OFF);
    chk("count cleared", 8'h00, rv);
    $display("test quiet done");
  endtask

  // zero recovery time keeps the FETs off
  task automatic t_norec();
    wr(REC_TIME_OFF, 8'h00);
    p.faults(1'b0, 3'b001);
    p.faults(1'b0, 3'h0);
    wait_fet(1'b1, 5);
    cycles(3 * SEC);
    chk("no recovery", 8'h01, 8'(fet_off));
    clear_all();
    $display("test norec done");
  endtask

  // thresholds 108 and 162, three consecutive samples
  task automatic t_otc();
    wr(OTC_THR_OFF, 8'h02);
    wr(OTC_DLY_OFF, 8'h02);
    wr(OTC_REC_OFF, 8'h03);
    p.sample(16'h006C);
    p.sample(16'h006B);
    p.sample(16'h006B);
    chk("otc at threshold", 8'h00, 8'(otc_alert));
    p.sample(16'h00C8);
    p.sample(16'h006B);
    p.sample(16'h006B);
    chk("otc two", 8'h00, 8'(otc_alert));
    p.sample(16'h006B);
    chk("otc set", 8'h01, 8'(otc_alert));
    p.sample(16'h00A2);
    chk("otc held", 8'h01, 8'(otc_alert));
    p.sample(16'h00A3);
    chk("otc released", 8'h00, 8'(otc_alert));
    rd(STATUS_OFF);
    chk("status otc", 8'h30, rv & 8'h30);
    $display("test otc done");
  endtask

  // Clock enable low freezes state: write and fault both ignored
  task automatic t_freeze();
    @(posedge mclk);
    ce <= 1'b0;
    wr(REC_TIME_OFF, 8'h22);
    p.faults(1'b0, 3'b001);
    p.faults(1'b0, 3'h0);
    @(posedge mclk);
    ce <= 1'b1;
    cycles(3);
    chk("frozen trip", 8'h00, 8'(fet_off));
    rd(REC_TIME_OFF);
    chk("frozen write", 8'h00, rv);
    $display("test freeze done");
  endtask

  // settings return to reset values after a mid-run reset
  task automatic t_reset();
    wr(SHORT_DLY_OFF, 8'h05);
    wr(LIMIT_OFF, 8'h03);
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    rd(SHORT_DLY_OFF);
    chk("short delay rst", 8'h01, rv);
    rd(LIMIT_OFF);
    chk("limit rst", 8'h00, rv);
    chk("irq rst", 8'h00, 8'(irq));
    $display("test reset done");
  endtask

  // ----------------------------------------
  // Main sequence and verdict
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    nrst        = 1'b0;
    ce          = 1'b1;
    wr_en       = 1'b0;
    rd_en       = 1'b0;
    latch_clear = 1'b0;
    addr        = 8'h00;
    wr_data     = 8'h00;
    error_cnt   = 0;
    num_checks  = 0;
    cyc         = 0;
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    t_regs();
    t_short();
    t_latch();
    t_quiet();
    t_norec();
    t_otc();
    t_freeze();
    t_reset();
    report_and_stop();
  end
endmodule
